// ===== design/wdg_counter.sv
// Watchdog counter with selectable overflow length.
`default_nettype none
module wdg_counter
  import wdg_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  wdg_tick_if.cnt   bus
);
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] limit;

  // Overflow length doubles with each select step, from 2^13 up to 2^20.
  assign limit = CNT_W'((1 << (13 + bus.sel)) - 1);
  assign bus.count = count_r;
  assign bus.ovf = bus.tick && (count_r == limit) && !bus.clear;

  // Counter clears on restart, holds without a tick and never self-zeroes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r <= '0;
    else if (bus.clear)
      count_r <= '0; // R12
    else if (bus.tick && count_r != limit)
      count_r <= count_r + 1'b1; // R9
  end
endmodule : wdg_counter
`default_nettype wire

// ===== design/wdg_pkg.sv
// Package of register offsets, field layouts and constants for the watchdog block.
`default_nettype none
package wdg_pkg;
  localparam logic [11:0] ADDR_KEY    = 12'h000;
  localparam logic [11:0] ADDR_MODE   = 12'h004;
  localparam logic [11:0] ADDR_CTRL   = 12'h008;
  localparam logic [11:0] ADDR_STAT   = 12'h00C;
  localparam logic [11:0] ADDR_MASK   = 12'h010;
  localparam logic [11:0] ADDR_COUNT  = 12'h014;
  localparam logic [7:0]  KEY_WRITE   = 8'hAC;
  localparam logic [7:0]  KEY_READ    = 8'h9A;
  localparam logic [7:0]  MODE_RESET  = 8'h67;
  localparam logic [2:0]  MODE_TOP    = 3'h3;
  localparam int          SEL_HIGH_BIT = 4;
  localparam int          SEL_LOW_BIT  = 3;
  localparam int          CTRL_BITOP  = 0;
  localparam int          ST_KEY      = 0;
  localparam int          ST_MODE2    = 1;
  localparam int          ST_BITOP    = 2;
  localparam int          ST_OVF      = 3;
  localparam int          ST_W        = 4;
  localparam int          CNT_W       = 20;
  localparam logic [3:0]  RST_PULSE   = 4'h8;
endpackage : wdg_pkg
`default_nettype wire

// ===== design/wdg_tick_if.sv
// Interface carrying the count enable and restart between the core and the counter.
`default_nettype none
interface wdg_tick_if;
  logic                  tick;
  logic                  clear;
  logic [2:0]            sel;
  logic                  ovf;
  logic [wdg_pkg::CNT_W-1:0] count;
  modport ctl (output tick, output clear, output sel, input ovf, input count);
  modport cnt (input tick, input clear, input sel, output ovf, output count);
endinterface : wdg_tick_if
`default_nettype wire

// ===== design/wdg_top.sv
// Watchdog with restart key, one-shot mode register, sleep handling and APB access.
// Operation
// R1: A key write other than ACH triggers the internal reset. The code gives none while mode bit 4 has stopped the watchdog.
// R2: A single-bit access to the key register triggers reset instead. The code gives none while mode bit 4 has stopped the watchdog.
// R3: Reading the key register returns 9AH.
// R4: With unstoppable oscillator the counter keeps counting during STOP.
// R5: Overflow during STOP in that setting produces the internal reset.
// R6: Software restarts the watchdog before overflow during STOP.
// R7: With stoppable oscillator the counter halts during HALT or STOP.
// R8: After wake-up counting resumes from the clock selected before sleep.
// R9: The count is held over sleep, never zeroed on wake-up.
// R10: Mode register takes one byte write; a second write resets. The code resets only if the first write left mode bit 4 clear.
// R11: Software writes top three mode bits as 0, 1, 1.
// R12: A correct ACH write clears the counter and counting continues.
// R13: Reaching the selected overflow count without restart resets.
//
// Implementation choices: the placing of the registers and the APB slave port.
`default_nettype none
module wdg_top
  import wdg_pkg::*;
#(
  parameter int LS_DIV = 8
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        osc_unstoppable,
  input  wire logic        halt_req,
  input  wire logic        stop_req,
  output logic             int_reset_req,
  output logic             irq
);
  typedef enum logic [2:0] {
    MS_FRESH = 3'b001,
    MS_SET   = 3'b010,
    MS_OFF   = 3'b100
  } wdg_mode_type;

  wdg_tick_if tif ();
  wdg_mode_type     mstate_r, mstate_nxt;
  logic [7:0]       mode_r;
  logic             bitop_r;
  logic [ST_W-1:0]  stat_r, mask_r;
  logic [31:0]      prdata_r;
  logic             int_reset_r, irq_r;
  logic [3:0]       rst_cnt_r;
  logic [15:0]      div_r;
  logic             uns_s1_r, uns_r, halt_s1_r, halt_r, stop_s1_r, stop_r;

  // Synchronise pin-level inputs before use.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      uns_s1_r  <= 1'b0;
      uns_r     <= 1'b0;
      halt_s1_r <= 1'b0;
      halt_r    <= 1'b0;
      stop_s1_r <= 1'b0;
      stop_r    <= 1'b0;
    end
    else
    begin
      uns_s1_r  <= osc_unstoppable;
      uns_r     <= uns_s1_r;
      halt_s1_r <= halt_req;
      halt_r    <= halt_s1_r;
      stop_s1_r <= stop_req;
      stop_r    <= stop_s1_r;
    end
  end

  // Bus decode; all accesses complete without wait states.
  wire acc      = psel && penable;
  wire wr       = acc && pwrite;
  wire hit_key  = paddr == ADDR_KEY;
  wire hit_mode = paddr == ADDR_MODE;
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_stat = paddr == ADDR_STAT;
  wire hit_mask = paddr == ADDR_MASK;
  wire hit_cnt  = paddr == ADDR_COUNT;
  wire mapped   = hit_key | hit_mode | hit_ctrl | hit_stat | hit_mask | hit_cnt;
  wire byte_ok  = pstrb[0];
  wire sel_hi   = mode_r[SEL_HIGH_BIT];
  wire stopped  = (mstate_r == MS_OFF);
  wire key_wr   = wr && hit_key && byte_ok;
  wire mode_wr  = wr && hit_mode && byte_ok;

  // Key access and mode write events; the bit-access flag marks single-bit manipulation.
  wire key_bad  = key_wr && !bitop_r && pwdata[7:0] != KEY_WRITE && !stopped; // R1
  wire key_bit  = acc && hit_key && bitop_r && !stopped; // R2
  wire key_good = key_wr && !bitop_r && pwdata[7:0] == KEY_WRITE; // R12
  wire mode2    = mode_wr && mstate_r == MS_SET; // R10

  // Counting gate: unstoppable mode keeps counting in STOP, else sleep halts it.
  wire sleeping = halt_r || stop_r;
  wire run_ok   = !stopped && (uns_r ? !halt_r : !sleeping); // R4 R7
  wire div_hit  = div_r == 16'(LS_DIV - 1);
  wire ovf_rst  = tif.ovf; // R5 R13
  wire any_rst  = key_bad | key_bit | mode2 | ovf_rst;

  assign tif.tick  = run_ok && div_hit;
  assign tif.clear = key_good;
  assign tif.sel   = mode_r[2:0]; // R8

  wdg_counter u_cnt (.pclk(pclk), .presetn(presetn), .bus(tif));

  // Low-speed tick divider; its phase is kept across sleep.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_r <= '0;
    else if (run_ok)
      div_r <= div_hit ? '0 : div_r + 1'b1;
  end

  // Mode register state: one write allowed, then locked.
  always_comb
  begin
    mstate_nxt = mstate_r;
    unique case (mstate_r)
      MS_FRESH: if (mode_wr) mstate_nxt = pwdata[SEL_HIGH_BIT] ? MS_OFF : MS_SET;
      MS_SET:   mstate_nxt = MS_SET;
      MS_OFF:   mstate_nxt = MS_OFF;
      default:  mstate_nxt = MS_FRESH;
    endcase
  end

  // Mode value, bit-access flag and mode state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mstate_r <= MS_FRESH;
      mode_r   <= MODE_RESET;
      bitop_r  <= 1'b0;
    end
    else
    begin
      mstate_r <= mstate_nxt;
      if (mode_wr && mstate_r == MS_FRESH)
        mode_r <= pwdata[7:0];
      if (wr && hit_ctrl && byte_ok)
        bitop_r <= pwdata[CTRL_BITOP];
    end
  end

  // Internal reset pulse, stretched for a fixed number of cycles.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_cnt_r   <= '0;
      int_reset_r <= 1'b0;
    end
    else
    begin
      if (any_rst)
        rst_cnt_r <= RST_PULSE;
      else if (rst_cnt_r != 4'h0)
        rst_cnt_r <= rst_cnt_r - 1'b1;
      int_reset_r <= any_rst || rst_cnt_r > 4'h1;
    end
  end

  // Sticky status with write-one-to-clear; a new event wins over the clear.
  wire [ST_W-1:0] ev  = {ovf_rst, key_bit, mode2, key_bad};
  wire [ST_W-1:0] w1c = (wr && hit_stat && byte_ok) ? pwdata[ST_W-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_r <= '0;
      mask_r <= '0;
      irq_r  <= 1'b0;
    end
    else
    begin
      stat_r <= (stat_r & ~w1c) | ev;
      if (wr && hit_mask && byte_ok)
        mask_r <= pwdata[ST_W-1:0];
      irq_r <= |(((stat_r & ~w1c) | ev) & mask_r);
    end
  end

  // Read data mux; the key register always reads back its fixed code.
  wire [31:0] rmux =
    hit_key  ? {24'h000000, KEY_READ} : // R3
    hit_mode ? {24'h000000, mode_r} :
    hit_ctrl ? {31'h00000000, bitop_r} :
    hit_stat ? {28'h0000000, stat_r} :
    hit_mask ? {28'h0000000, mask_r} :
    hit_cnt  ? {12'h000, tif.count} : 32'h00000000;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= '0;
    else if (psel && !penable && !pwrite)
      prdata_r <= rmux;
  end

  assign prdata        = prdata_r;
  assign pready        = 1'b1;
  assign pslverr       = 1'b0;
  assign int_reset_req = int_reset_r;
  assign irq           = irq_r;
  wire unused = mapped;

  a_bad_key: assert property (@(posedge pclk) disable iff (!presetn)
    key_bad |=> int_reset_req) else $error("Bad key gave no reset."); // R1
  a_bit_access: assert property (@(posedge pclk) disable iff (!presetn)
    key_bit |=> int_reset_req ##1 int_reset_req) else $error("Bit access gave no reset."); // R2
  a_key_read: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit_key |=> prdata[7:0] == 8'h9A)
    else $error("Key read wrong."); // R3
  a_stop_count: assert property (@(posedge pclk) disable iff (!presetn)
    uns_r && stop_r && !halt_r && !stopped && tif.tick && !tif.clear && !tif.ovf
    |=> tif.count == $past(tif.count) + 1'b1) else $error("No count in stop."); // R4
  a_sleep_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !uns_r && sleeping && !tif.clear |=> tif.count == $past(tif.count))
    else $error("Count moved in sleep."); // R7 R9
  a_ovf_reset: assert property (@(posedge pclk) disable iff (!presetn)
    tif.ovf |=> int_reset_req [*7]) else $error("Overflow reset short."); // R5 R13
  a_mode_once: assert property (@(posedge pclk) disable iff (!presetn)
    mode2 |=> int_reset_req && mode_r == $past(mode_r)) else $error("Second write."); // R10
  a_key_clear: assert property (@(posedge pclk) disable iff (!presetn)
    key_good |=> tif.count == '0) else $error("Restart no clear."); // R12
  a_sel_kept: assert property (@(posedge pclk) disable iff (!presetn)
    mstate_r != MS_FRESH |=> tif.sel == $past(tif.sel)) else $error("Select moved."); // R8
  c_restart: cover property (@(posedge pclk) key_good);
  c_overflow: cover property (@(posedge pclk) tif.ovf);
  c_stop_run: cover property (@(posedge pclk) uns_r && stop_r && tif.tick);
endmodule : wdg_top
`default_nettype wire

// ===== tb/wdg_top_bench.sv
// Self-checking bench for the watchdog top with APB register access.
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module wdg_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import wdg_pkg::*;
  typedef struct packed {logic [31:0] lo; logic [31:0] hi;} wdg_exp_type;
  logic        pclk, presetn, psel, penable, pwrite, osc_unstoppable, halt_req, stop_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [3:0]  pstrb;
  logic        pready, pslverr, int_reset_req, irq;
  int          n_fail, tests_run, cyc, seed;
  wdg_exp_type exp_q[$];
  wdg_exp_type cur;
  wdg_top #(.LS_DIV(1)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_unstoppable(osc_unstoppable),
    .halt_req(halt_req), .stop_req(stop_req), .int_reset_req(int_reset_req), .irq(irq));
  // Prints the verdict and ends the run.
  task stop_test;
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One APB transfer; holds the request until pready is seen high at a rising edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    // Lets one edge pass so a following call never reassigns psel in the same step.
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  // Notes the expected read range, then performs the read.
  task rd(input logic [11:0] a, input logic [31:0] lo, input logic [31:0] hi);
    exp_q.push_back('{lo: lo, hi: hi});
    apb(1'b0, a, 32'h0000_0000, 4'h0);
  endtask
  // Compares the reset request and interrupt levels in mid-cycle.
  task lvl(input logic er, input logic ei);
    @(negedge pclk);
    `CHK("int_reset_req", er, int_reset_req)
    `CHK("irq", ei, irq)
    @(posedge pclk);
  endtask
  // Generates the clock.
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Takes the oldest note off the queue at each completed read and compares it.
  always @(posedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1)
    begin
      cur = exp_q.pop_front();
      `CHK("prdata", cur.lo, (prdata >= cur.lo && prdata <= cur.hi) ? cur.lo : prdata)
      `CHK("pslverr", 1'b0, pslverr)
    end
  end
  // Cuts a hang short.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_fail++;
      stop_test;
    end
  end
  // Main sequence.
  initial
  begin
    n_fail = 0; tests_run = 0; cyc = 0; seed = 32'h6878418B;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; pstrb = 4'h0; osc_unstoppable = 1'b0; halt_req = 1'b0; stop_req = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_KEY, 32'h9A, 32'h9A);
    wr(12'h020, 32'h55);
    rd(12'h020, 32'h0, 32'h0);
    wr(ADDR_MODE, 32'h60);
    wr(ADDR_KEY, 32'hAC);
    rd(ADDR_COUNT, 32'h0, 32'h8);
    apb(1'b1, ADDR_KEY, 32'h00, 4'hE);
    rd(ADDR_STAT, 32'h0, 32'h0);
    wr(ADDR_MASK, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      v = $random(seed);
      if (v[7:0] == KEY_WRITE)
        v[0] = ~v[0];
      wr(ADDR_KEY, {24'h0, v[7:0]});
      rd(ADDR_STAT, 32'h1, 32'h1);
      lvl(1'b1, 1'b1);
      wr(ADDR_STAT, 32'hF);
    end
    wr(ADDR_KEY, 32'h5A);
    wr(ADDR_MASK, 32'h0);
    repeat (10) @(posedge pclk);
    lvl(1'b0, 1'b0);
    wr(ADDR_STAT, 32'hF);
    wr(ADDR_MODE, 32'h61);
    rd(ADDR_STAT, 32'h2, 32'h2);
    wr(ADDR_STAT, 32'hF);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_KEY, 32'hAC);
    rd(ADDR_STAT, 32'h4, 32'h4);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_STAT, 32'hF);
    // Stoppable oscillator: count freezes in HALT and STOP and resumes from its value.
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_KEY, 32'hAC);
      halt_req <= (i == 0);
      stop_req <= (i == 1);
      repeat (4) @(posedge pclk);
      rd(ADDR_COUNT, 32'h0, 32'h10);
      repeat (200) @(posedge pclk);
      rd(ADDR_COUNT, 32'h0, 32'h10);
      halt_req <= 1'b0;
      stop_req <= 1'b0;
      repeat (100) @(posedge pclk);
      rd(ADDR_COUNT, 32'd90, 32'd125);
    end
    // Unstoppable oscillator: STOP keeps counting; restarts hold off overflow.
    osc_unstoppable <= 1'b1;
    stop_req <= 1'b1;
    wr(ADDR_STAT, 32'hF);
    wr(ADDR_KEY, 32'hAC);
    repeat (5000) @(posedge pclk);
    rd(ADDR_COUNT, 32'd4990, 32'd5020);
    wr(ADDR_KEY, 32'hAC);
    repeat (5000) @(posedge pclk);
    rd(ADDR_STAT, 32'h0, 32'h0);
    repeat (3300) @(posedge pclk);
    rd(ADDR_STAT, 32'h8, 32'h8);
    stop_req <= 1'b0;
    if (exp_q.size() != 0)
      n_fail++;
    stop_test;
  end
endmodule // wdg_top_bench
`undef CHK
`default_nettype wire
